// ### fsa_pkg.sv
// Package of constants for the flash security access gate
package fsa_pkg;
   localparam int ADDR_W = 21;
   localparam logic [ADDR_W-1:0] FPW_A_ADDR = 21'h14_8000;
   localparam logic [ADDR_W-1:0] BPW_A_ADDR = 21'h14_8004;
   localparam logic [ADDR_W-1:0] FPW_B_ADDR = 21'h14_8008;
   localparam logic [ADDR_W-1:0] BPW_B_ADDR = 21'h14_800C;
   localparam int RD_PROT_BIT = 16;
   localparam int WR_PROT_BIT = 17;
   localparam int WR_LVL_BIT = 18;
   localparam int RSVD_LSB = 19;
   localparam int RSVD_MSB = 31;
   localparam int SECT_LSB = 0;
   localparam int SMALL_SECTORS = 8;
   localparam logic [2:0] MODE_INTERNAL_VECTOR_MODE = 3'h0;
   localparam int SECT_SEL_LSB = 13;
   localparam logic [ADDR_W-1:0] SMALL_BASE = 21'h14_0000;
   localparam int SMALL_SEL_W = 3;
   localparam int WORD_CNT = 4;
   localparam logic [1:0] IDX_FPW_A = 2'h0;
   localparam logic [1:0] IDX_BPW_A = 2'h1;
   localparam logic [1:0] IDX_FPW_B = 2'h2;
   localparam logic [1:0] IDX_BPW_B = 2'h3;
   typedef enum logic [3:0] {
      FSA_IDLE  = 4'b0001,
      FSA_REQ   = 4'b0010,
      FSA_WAIT  = 4'b0100,
      FSA_READY = 4'b1000
   } fsa_state_e;
endpackage

// ### fsa_vec_store.sv
// Small register store holding the four fetched security words
`timescale 1ns/1ps
module fsa_vec_store
   import fsa_pkg::*;
#(
   parameter int DATA_W = 32
) (
   input wire logic clk, // System clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic wr_en, // Write strobe
   input wire logic [1:0] wr_idx, // Word index to write
   input wire logic [DATA_W-1:0] wr_data, // Word to store
   input wire logic [1:0] rd_idx, // Word index to read
   output logic [DATA_W-1:0] rd_data // Registered read data
);
   logic [DATA_W-1:0] mem_r [WORD_CNT];

   // Storage words, cleared so nothing protected leaks before the fetch
   genvar gi;
   generate
      for (gi = 0; gi < WORD_CNT; gi++) begin : g_word
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               mem_r[gi] <= '0;
            end else if (wr_en && wr_idx == 2'(gi)) begin
               mem_r[gi] <= wr_data;
            end
         end
      end
   endgenerate

   // Registered read port
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem_r[rd_idx];
      end
   end
endmodule

// ### fsa_gate.sv
// Flash security access gate: vector fetch, decode and access blocking
//
// Overview of operation
// - Fetch security words from fixed flash addresses
// - Mode bits 31..16; 31..19 must be zero
// - Bit 16 blocks reads except internal-vector mode
// - Bit 17 without 18 blocks writes everywhere
// - Bits 17,18 block writes except internal-vector mode
// - Bits 16,17 block reads and all writes
// - Bits 18,16 block reads only
// - Per small sector write protect bits block writes
// - No flash access before vectors fetched
`timescale 1ns/1ps
module fsa_gate
   import fsa_pkg::*;
#(
   parameter int DATA_W = 32,
   parameter int FETCH_LAT = 2
) (
   input wire logic clk, // System clock, 250 MHz
   input wire logic rst, // Asynchronous reset, active high
   input wire logic [2:0] operating_mode_pins, // Mode pins, asynchronous
   output logic fetch_req, // Flash read request for vector fetch
   output logic [ADDR_W-1:0] fetch_addr, // Vector fetch address
   input wire logic fetch_valid, // Fetch data valid
   input wire logic [DATA_W-1:0] fetch_data, // Fetch read data
   input wire logic acc_req, // Flash access request
   input wire logic acc_write, // Access is a write
   input wire logic [ADDR_W-1:0] acc_addr, // Access address
   output logic acc_grant, // Access allowed
   output logic acc_block, // Access refused
   output logic vec_ready, // Security vectors fetched
   output logic read_protected, // Read blocking active
   output logic write_protected, // Global write blocking active
   output logic [DATA_W-1:0] flash_protect_word_a, // Fetched first flash word
   output logic [DATA_W-1:0] boot_protect_word_a // Fetched first boot word
);
   fsa_state_e state_r, state_nxt;
   logic [1:0] idx_r;
   logic [2:0] mode_s1_r, mode_s2_r;
   logic rd_prot_r, wr_prot_r, wr_lvl_r;
   logic [SMALL_SECTORS-1:0] sect_wp_r;
   logic [DATA_W-1:0] rd_word;
   logic [ADDR_W-1:0] addr_table [WORD_CNT];

   // Mode pins come from outside; two flops before any use
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_s1_r <= '0;
         mode_s2_r <= '0;
      end else begin
         mode_s1_r <= operating_mode_pins;
         mode_s2_r <= mode_s1_r;
      end
   end

   assign addr_table[0] = FPW_A_ADDR;
   assign addr_table[1] = BPW_A_ADDR;
   assign addr_table[2] = FPW_B_ADDR;
   assign addr_table[3] = BPW_B_ADDR;

   // Fetch sequencer walks the four vectors in order
   wire last_word = (idx_r == IDX_BPW_B);
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         FSA_IDLE: state_nxt = FSA_REQ;
         FSA_REQ: state_nxt = FSA_WAIT;
         FSA_WAIT: begin
            if (fetch_valid) begin
               state_nxt = last_word ? FSA_READY : FSA_REQ;
            end
         end
         FSA_READY: state_nxt = FSA_READY; // Held until reset
         default: state_nxt = FSA_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= FSA_IDLE;
         idx_r <= IDX_FPW_A;
      end else begin
         state_r <= state_nxt;
         if (state_r == FSA_WAIT && fetch_valid && !last_word) begin
            idx_r <= idx_r + 2'h1;
         end
      end
   end

   wire store_en = (state_r == FSA_WAIT) && fetch_valid;

   fsa_vec_store #(.DATA_W(DATA_W)) u_store (
      .clk(clk),
      .rst(rst),
      .wr_en(store_en),
      .wr_idx(idx_r),
      .wr_data(fetch_data),
      .rd_idx(IDX_BPW_A),
      .rd_data(rd_word)
   );

   // Decode of the first flash word as it arrives
   wire [DATA_W-1:0] fw = fetch_data;
   wire rsvd_ok = (fw[RSVD_MSB:RSVD_LSB] == '0);
   wire [2:0] lvl = {fw[WR_LVL_BIT], fw[WR_PROT_BIT], fw[RD_PROT_BIT]};
   // Listed codes only; others fall back to no read or global write blocking, sector bits still apply
   wire listed = rsvd_ok && (lvl != 3'h0) && (lvl != 3'h4);
   wire cap_a = store_en && (idx_r == IDX_FPW_A);

   // Protection settings captured once after reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_prot_r <= 1'b0;
         wr_prot_r <= 1'b0;
         wr_lvl_r <= 1'b0;
         sect_wp_r <= '0;
         flash_protect_word_a <= '0;
      end else if (cap_a) begin
         rd_prot_r <= listed & fw[RD_PROT_BIT];
         wr_prot_r <= listed & fw[WR_PROT_BIT];
         wr_lvl_r <= listed & fw[WR_LVL_BIT];
         sect_wp_r <= fw[SECT_LSB +: SMALL_SECTORS];
         flash_protect_word_a <= fw;
      end
   end

   // Access decision; the internal-vector exemption follows the mode pins
   wire internal_vector_mode = (mode_s2_r == MODE_INTERNAL_VECTOR_MODE);
   wire rd_blk = rd_prot_r && !internal_vector_mode;
   wire wr_glob = wr_prot_r && !(wr_lvl_r && internal_vector_mode);
   wire in_small = (acc_addr[ADDR_W-1:SECT_SEL_LSB+SMALL_SEL_W] ==
                    SMALL_BASE[ADDR_W-1:SECT_SEL_LSB+SMALL_SEL_W]);
   wire [SMALL_SEL_W-1:0] sect = acc_addr[SECT_SEL_LSB +: SMALL_SEL_W];
   wire sect_blk = in_small && sect_wp_r[sect];
   wire rdy = (state_r == FSA_READY);
   wire deny = !rdy || (acc_write ? (wr_glob || sect_blk) : rd_blk);

   // Registered outputs; decision lands one cycle after the request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_grant <= 1'b0;
         acc_block <= 1'b0;
         vec_ready <= 1'b0;
         read_protected <= 1'b0;
         write_protected <= 1'b0;
         fetch_req <= 1'b0;
         fetch_addr <= '0;
         boot_protect_word_a <= '0;
      end else begin
         acc_grant <= acc_req && !deny;
         acc_block <= acc_req && deny;
         vec_ready <= rdy;
         read_protected <= rd_blk;
         write_protected <= wr_glob;
         fetch_req <= (state_nxt == FSA_REQ);
         fetch_addr <= addr_table[state_nxt == FSA_REQ && state_r == FSA_WAIT ? idx_r + 2'h1 : idx_r];
         boot_protect_word_a <= rd_word;
      end
   end

   // Checks kept beside the logic
   sequence s_fetch_done;
      store_en && last_word;
   endsequence
   property p_no_grant_early;
      @(posedge clk) disable iff (rst) !rdy |=> !acc_grant;
   endproperty
   a_no_grant_early: assert property (p_no_grant_early) else $error("grant before fetch");
   property p_ready_after_fetch;
      @(posedge clk) disable iff (rst) s_fetch_done |=> ##1 vec_ready;
   endproperty
   a_ready_after_fetch: assert property (p_ready_after_fetch) else $error("ready late");
   property p_read_blk;
      @(posedge clk) disable iff (rst) acc_req && !acc_write && rdy && rd_prot_r && !internal_vector_mode |=> acc_block;
   endproperty
   a_read_blk: assert property (p_read_blk) else $error("read not blocked");
   property p_write_all;
      @(posedge clk) disable iff (rst) acc_req && acc_write && wr_prot_r && !wr_lvl_r |=> acc_block;
   endproperty
   a_write_all: assert property (p_write_all) else $error("write not blocked");
   property p_write_internal_vector_mode;
      @(posedge clk) disable iff (rst)
         acc_req && acc_write && rdy && wr_lvl_r && internal_vector_mode && !sect_blk |=> acc_grant;
   endproperty
   a_write_internal_vector_mode: assert property (p_write_internal_vector_mode) else $error("internal_vector_mode write refused");
   property p_sector;
      @(posedge clk) disable iff (rst) acc_req && acc_write && sect_blk |=> acc_block;
   endproperty
   a_sector: assert property (p_sector) else $error("sector write allowed");
   property p_stable;
      @(posedge clk) disable iff (rst) rdy |=> $stable(rd_prot_r) && $stable(wr_prot_r);
   endproperty
   a_stable: assert property (p_stable) else $error("protection changed");
   property p_fetch_addr;
      @(posedge clk) disable iff (rst) fetch_req && idx_r == IDX_FPW_A |-> fetch_addr == FPW_A_ADDR;
   endproperty
   a_fetch_addr: assert property (p_fetch_addr) else $error("wrong vector address");
   property p_unlisted;
      @(posedge clk) disable iff (rst) cap_a && !rsvd_ok |=> !rd_prot_r && !wr_prot_r;
   endproperty
   a_unlisted: assert property (p_unlisted) else $error("bad code protected");
endmodule

// ### fsa_flash_model.sv
// Flash responder model that answers the security vector fetch
`timescale 1ns/1ps
module fsa_flash_model
   import fsa_pkg::*;
(
   clk, // System clock
   rst, // Reset, active high
   slow, // Stretch the answer latency
   word_a, // Contents of the first flash word
   fetch_req, // Vector read request
   fetch_addr, // Vector read address
   fetch_valid, // Read data strobe
   fetch_data // Read data
);
   input wire logic clk;
   input wire logic rst;
   input wire logic slow;
   input wire logic [31:0] word_a;
   input wire logic fetch_req;
   input wire logic [ADDR_W-1:0] fetch_addr;
   output logic fetch_valid;
   output logic [31:0] fetch_data;
   logic busy_r;
   logic [3:0] wait_r;
   logic [ADDR_W-1:0] addr_r;
   // Each vector address except BPW_B_ADDR gives a distinct word so a wrong address shows up
   function automatic logic [31:0] word_at(logic [ADDR_W-1:0] a);
      case (a)
         FPW_A_ADDR: word_at = word_a;
         BPW_A_ADDR: word_at = ~word_a ^ 32'h0000_5a5a;
         FPW_B_ADDR: word_at = 32'hffff_ffff;
         default: word_at = 32'h0000_0000;
      endcase
   endfunction
   // Latch one request, answer after 1 or 6 cycles; data bus toggles once released
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_r <= 1'b0;
         fetch_valid <= 1'b0;
         wait_r <= 4'h0;
         addr_r <= '0;
         fetch_data <= 32'h0000_0000;
      end else begin
         fetch_valid <= 1'b0;
         if (fetch_valid)
            fetch_data <= ~fetch_data;
         if (!busy_r && !fetch_valid && fetch_req) begin
            busy_r <= 1'b1;
            addr_r <= fetch_addr;
            wait_r <= slow ? 4'h5 : 4'h0;
         end else if (busy_r && wait_r == 4'h0) begin
            busy_r <= 1'b0;
            fetch_valid <= 1'b1;
            fetch_data <= word_at(addr_r);
         end else if (busy_r)
            wait_r <= wait_r - 4'h1;
      end
   end
endmodule

// ### flash_security_access_tb_top.sv
// Self-checking bench for the flash security access gate
`timescale 1ns/1ps
module flash_security_access_tb_top;
   import fsa_pkg::*;
   logic clk, rst, slow, acc_req, acc_write, fetch_req, fetch_valid;
   logic acc_grant, acc_block, vec_ready, read_protected, write_protected;
   logic [2:0] mode;
   logic [ADDR_W-1:0] acc_addr, fetch_addr;
   logic [31:0] word_a, fetch_data, fpw_a, bpw_a;
   int failures, n_checks, seed;
   fsa_gate i_fsa_gate (.clk(clk), .rst(rst), .operating_mode_pins(mode), .fetch_req(fetch_req),
      .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .fetch_data(fetch_data), .acc_req(acc_req),
      .acc_write(acc_write), .acc_addr(acc_addr), .acc_grant(acc_grant), .acc_block(acc_block),
      .vec_ready(vec_ready), .read_protected(read_protected), .write_protected(write_protected),
      .flash_protect_word_a(fpw_a), .boot_protect_word_a(bpw_a));
   fsa_flash_model i_fsa_flash_model (.clk(clk), .rst(rst), .slow(slow), .word_a(word_a),
      .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .fetch_data(fetch_data));
   // Bit 0 read blocking, bit 1 write blocking; unlisted codes protect nothing
   function automatic logic [1:0] prot(logic [31:0] w, logic [2:0] m);
      logic ok, ni;
      ok = (w[31:19] == 13'h0000);
      ni = (m != MODE_INTERNAL_VECTOR_MODE);
      prot[0] = ok && w[16] && ni;
      prot[1] = ok && w[17] && (!w[18] || ni);
   endfunction
   // Expected refusal of one access
   function automatic logic blk(logic [31:0] w, logic [2:0] m, logic wr, logic [ADDR_W-1:0] a);
      logic [1:0] p;
      p = prot(w, m);
      blk = wr ? (p[1] || (a[20:16] == SMALL_BASE[20:16] && w[a[15:13]])) : p[0];
   endfunction
   task automatic check(logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Request stays up until the answer edge, so calls may run back to back
   task automatic access(logic wr, logic [ADDR_W-1:0] a, logic exp);
      acc_req = 1'b1;
      acc_write = wr;
      acc_addr = a;
      @(posedge clk);
      #1;
      check(32'({acc_grant, acc_block}), 32'({~exp, exp}));
   endtask
   // Reset, probe an early access, then wait for the fetch with a bound
   task automatic do_reset();
      rst = 1'b1;
      repeat (10) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      access(1'b0, 21'h04_0000, 1'b1);
      acc_req = 1'b0;
      // Stands in for the programmer's long start-up wait, cut short to the fetch time
      for (int i = 0; i < 200 && vec_ready !== 1'b1; i++)
         @(posedge clk);
      repeat (4) @(posedge clk);
      #1;
      check(32'(vec_ready), 32'h0000_0001);
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Full run is near 1000 cycles, so this only trips on a hang
   initial begin
      repeat (40000) @(posedge clk);
      failures++;
      wrap_up();
   end
   initial begin
      logic [31:0] w;
      logic [2:0] m;
      logic [ADDR_W-1:0] a;
      logic wr;
      rst = 1'b1;
      slow = 1'b0;
      acc_req = 1'b0;
      acc_write = 1'b0;
      acc_addr = '0;
      mode = 3'h0;
      word_a = 32'h0000_0000;
      failures = 0;
      n_checks = 0;
      seed = 41;
      // Every code of bits 18..16 in both mode classes, then reserved bits set
      for (int t = 0; t < 18; t++) begin
         w = $random(seed);
         w[31:19] = (t >= 16) ? 13'h1000 : 13'h0000;
         w[18:16] = (t >= 16) ? 3'h7 : t[2:0];
         m = (t[3] || (t[4] && t[0])) ? (3'h1 + 3'($unsigned($random(seed)) % 7)) : MODE_INTERNAL_VECTOR_MODE;
         mode = m;
         slow = t[0];
         word_a = w;
         do_reset();
         check(fpw_a, w);
         check(bpw_a, ~w ^ 32'h0000_5a5a);
         check(32'({write_protected, read_protected}), 32'(prot(w, m)));
         access(1'b1, 21'h14_0000, blk(w, m, 1'b1, 21'h14_0000));
         access(1'b1, 21'h14_fffe, blk(w, m, 1'b1, 21'h14_fffe));
         for (int i = 0; i < 12; i++) begin
            a = 21'($random(seed));
            if (i[0]) begin
               a[20:16] = 5'h14;
               a[0] = 1'b0; // Programmer-style access keeps bit 0 low, bit 20 high
            end
            wr = 1'($random(seed));
            access(wr, a, blk(w, m, wr, a));
         end
         acc_req = 1'b0;
         // New flash contents must not leak into the settings held since reset
         word_a = ~w;
         repeat (3) @(posedge clk);
         #1;
         access(1'b1, 21'h14_0000, blk(w, m, 1'b1, 21'h14_0000));
         acc_req = 1'b0;
         check(fpw_a, w);
         $display("test %0d done", t);
      end
      wrap_up();
   end
endmodule
